/* File: mpr_pkg.sv */
`default_nettype none

package mpr_pkg;

   // Storage slots; pairs come first, high word at the even slot
   typedef enum logic [4:0] {
      MPR_I_ROTOR_HI = 5'h00, MPR_I_ROTOR_LO = 5'h01,
      MPR_I_IND_HI   = 5'h02, MPR_I_IND_LO   = 5'h03,
      MPR_I_MAG_HI   = 5'h04, MPR_I_MAG_LO   = 5'h05,
      MPR_I_INERT_HI = 5'h06, MPR_I_INERT_LO = 5'h07,
      MPR_I_ACC1_HI  = 5'h08, MPR_I_ACC1_LO  = 5'h09,
      MPR_I_DEC1_HI  = 5'h0A, MPR_I_DEC1_LO  = 5'h0B,
      MPR_I_STEP_HI  = 5'h0C, MPR_I_STEP_LO  = 5'h0D,
      MPR_I_ACC2_HI  = 5'h0E, MPR_I_ACC2_LO  = 5'h0F,
      MPR_I_DEC2_HI  = 5'h10, MPR_I_DEC2_LO  = 5'h11,
      MPR_I_PI_P     = 5'h12, MPR_I_PI_I     = 5'h13,
      MPR_I_P_P      = 5'h14, MPR_I_ZERO     = 5'h15,
      MPR_I_BOOST    = 5'h16, MPR_I_BASE     = 5'h17,
      MPR_I_MAX      = 5'h18, MPR_I_TBV      = 5'h19,
      MPR_I_TBF      = 5'h1A, MPR_I_CTRL     = 5'h1B,
      MPR_I_THERM    = 5'h1C, MPR_I_CURVE    = 5'h1D,
      MPR_I_STAB     = 5'h1E, MPR_I_CAP      = 5'h1F
   } mpr_idx_type;

   localparam int          MPR_NUM_REGS   = 32;
   localparam int          MPR_NUM_PAIRS  = 9;
   localparam logic [4:0]  MPR_PAIR_LAST  = 5'h11;
   localparam logic [15:0] MPR_ADDR_ADJUST = 16'h0001;
   localparam logic [31:0] MPR_STEP_SCALE = 32'h0000_0064;
   localparam logic [7:0]  MPR_EXC_ADDR   = 8'h02;
   localparam logic [7:0]  MPR_EXC_VALUE  = 8'h03;
   localparam logic [7:0]  MPR_EXC_NONE   = 8'h00;

   typedef struct packed {
      logic [15:0] num;
      logic [31:0] lo;
      logic [31:0] hi;
      logic [15:0] rst;
   } mpr_desc_type;

   // Register number, least value, greatest value, reset word
   localparam mpr_desc_type MPR_DESC [MPR_NUM_REGS] = '{
      '{16'h2526, 32'h0000_0001, 32'h0000_FFFF, 16'h0000},  // Tuned rotor resistance
      '{16'h2527, 32'h0000_0001, 32'h0000_FFFF, 16'h0001},
      '{16'h2528, 32'h0000_0001, 32'h0000_FFFF, 16'h0000},  // Tuned inductance
      '{16'h2529, 32'h0000_0001, 32'h0000_FFFF, 16'h0001},
      '{16'h252A, 32'h0000_0001, 32'h0000_FFFF, 16'h0000},  // Tuned magnetizing current
      '{16'h252B, 32'h0000_0001, 32'h0000_FFFF, 16'h0001},
      '{16'h252C, 32'h0000_0001, 32'h0098_9298, 16'h0000},  // Tuned inertia
      '{16'h252D, 32'h0000_0001, 32'h0098_9298, 16'h0001},
      '{16'h3103, 32'h0000_0001, 32'h0005_7E40, 16'h0000},  // First accel time
      '{16'h3104, 32'h0000_0001, 32'h0005_7E40, 16'h0001},
      '{16'h3105, 32'h0000_0001, 32'h0005_7E40, 16'h0000},  // First decel time
      '{16'h3106, 32'h0000_0001, 32'h0005_7E40, 16'h0001},
      '{16'h3216, 32'h0000_0000, 32'h0000_9C40, 16'h0000},  // Step speed zero
      '{16'h3217, 32'h0000_0000, 32'h0000_9C40, 16'h0000},
      '{16'h326D, 32'h0000_0001, 32'h0005_7E40, 16'h0000},  // Second accel time
      '{16'h326E, 32'h0000_0001, 32'h0005_7E40, 16'h0001},
      '{16'h326F, 32'h0000_0001, 32'h0005_7E40, 16'h0000},  // Second decel time
      '{16'h3270, 32'h0000_0001, 32'h0005_7E40, 16'h0001},
      '{16'h253D, 32'h0000_0000, 32'h0000_2710, 16'h0000},  // PI proportional
      '{16'h253E, 32'h0000_0000, 32'h0000_2710, 16'h0000},  // PI integral
      '{16'h253F, 32'h0000_0000, 32'h0000_03E8, 16'h0000},  // P proportional
      '{16'h2547, 32'h0000_0000, 32'h0000_03E8, 16'h0000},  // Zero hz limit
      '{16'h2548, 32'h0000_0000, 32'h0000_0032, 16'h0000},  // Start boost
      '{16'h3203, 32'h0000_001E, 32'h0000_0190, 16'h003C},  // Base frequency
      '{16'h3204, 32'h0000_001E, 32'h0000_0190, 16'h003C},  // Max frequency
      '{16'h323C, 32'h0000_0000, 32'h0000_00C8, 16'h0000},  // Boost voltage
      '{16'h323D, 32'h0000_0000, 32'h0000_01F4, 16'h0000},  // Boost frequency
      '{16'h323E, 32'h0000_0000, 32'h0000_0001, 16'h0000},  // Control method
      '{16'h330C, 32'h0000_00C8, 32'h0000_03E8, 16'h03E8},  // Thermal level
      '{16'h330D, 32'h0000_0000, 32'h0000_0002, 16'h0000},  // Thermal curve
      '{16'h3507, 32'h0000_0000, 32'h0000_00FF, 16'h0000},  // Stabilization
      '{16'h2503, 32'h0000_0000, 32'h0000_0018, 16'h0000}   // Capacity code
   };

   typedef logic [MPR_NUM_REGS-1:0][15:0] mpr_word_array_type;

   typedef struct packed {
      logic        write;
      logic [15:0] addr;
      logic [15:0] data;
   } mpr_req_type;

   typedef struct packed {
      logic        exc;
      logic [7:0]  exc_code;
      logic [15:0] data;
   } mpr_rsp_type;

   // Capacity codes without a rated power are holes in the range
   function automatic logic mpr_cap_legal(input logic [31:0] code);
      mpr_cap_legal = (code <= MPR_DESC[MPR_I_CAP].hi) &&
                      (code != 32'h0000_0001) && (code != 32'h0000_0003) &&
                      (code != 32'h0000_0005) && (code != 32'h0000_0008) &&
                      (code != 32'h0000_000A);
   endfunction : mpr_cap_legal

endpackage : mpr_pkg

`default_nettype wire

/* File: mpr_bank.sv */
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Request address is register number minus one; bank adds one back.
// - 32-bit values use two registers, high word at the lower number.
// - Tuned magnetizing current pair accepts 1 to 65535.
// - Tuned inertia pair accepts 1 to 9999000.
// - PI proportional and integral gains accept 0 to 10000.
// - P proportional gain accepts 0 to 1000.
// - Zero hz limit accepts 0 to 1000; start boost 0 to 50.
// - Capacity codes 0 to 24, codes 1,3,5,8,10 unassigned.
// - First accel and decel time pairs accept 1 to 360000.
// - Max frequency stored base to 400; base frequency 30 to stored max.
// - Step speed zero pair is zero or start frequency to max frequency.
// - Torque boost voltage 0 to 200, boost frequency 0 to 500.
// - Second accel and decel time pairs accept 1 to 360000.
// - Thermal level accepts 200 to 1000.
// - Stabilization gain accepts 0 to 255.
module mpr_bank
   import mpr_pkg::*;
#(
   parameter logic [31:0] STEP_START_MIN = 32'h0000_0032
)
(
   // Clock, reset, enable
   input  wire logic            core_clk_in,
   input  wire logic            rst_n_in,
   input  wire logic            ce_in,
   // Request from the frame engine
   input  wire logic            req_valid_in,
   input  wire mpr_req_type     req_in,
   // Answer to the frame engine
   output logic                 rsp_valid_out,
   output mpr_rsp_type          rsp_out,
   // Committed parameter words to the drive
   output mpr_word_array_type   param_words_out
);

   mpr_word_array_type          word_q;
   logic [MPR_NUM_PAIRS-1:0][15:0] pend_hi;
   logic                        hit;
   mpr_idx_type                 idx;
   logic                        is_pair;
   logic                        is_hi;
   logic [3:0]                  pair_sel;
   logic [31:0]                 cand;
   logic [31:0]                 step_ceiling;
   logic                        in_range;
   logic                        ok;
   logic [15:0]                 rd_word;
   logic                        acc;
   logic                        wr_commit;
   logic [5:0]                  dec;

   function automatic logic [5:0] decode(input logic [15:0] maddr);
      logic [15:0] num;
      num    = maddr + MPR_ADDR_ADJUST;
      decode = '0;
      for (int i = 0; i < MPR_NUM_REGS; i++) begin
         if (MPR_DESC[i].num == num) begin
            decode = {1'b1, 5'(i)};
         end
      end
   endfunction : decode

   // Table range check, shared by the write path and the storage assertions
   function automatic logic desc_ok(input logic [31:0] v, input mpr_idx_type i);
      desc_ok = (v >= MPR_DESC[i].lo) && (v <= MPR_DESC[i].hi);
   endfunction : desc_ok

   // Committed single word against its own table range
   function automatic logic word_ok(input mpr_word_array_type w, input mpr_idx_type i);
      word_ok = desc_ok({16'h0000, w[i]}, i);
   endfunction : word_ok

   // Committed 32-bit value of the pair whose high half sits at hi_i
   function automatic logic [31:0] pair_word(input mpr_word_array_type w, input logic [4:0] hi_i);
      pair_word = {w[hi_i], w[{hi_i[4:1], 1'b1}]};
   endfunction : pair_word

   assign acc = ce_in && req_valid_in;

   always_comb begin
      dec        = decode(req_in.addr);
      hit        = dec[5];
      idx        = mpr_idx_type'(dec[4:0]);
      is_pair    = hit && (idx <= MPR_PAIR_LAST);
      is_hi      = is_pair && !idx[0];
      pair_sel   = is_pair ? idx[4:1] : 4'h0;
      cand       = is_pair ? {pend_hi[pair_sel], req_in.data} : {16'h0000, req_in.data};
      rd_word    = hit ? word_q[idx] : 16'h0000;
   end

   // Cross-register limits read the committed words, never a pending half
   always_comb begin
      step_ceiling = 32'({16'h0000, word_q[MPR_I_MAX]} * MPR_STEP_SCALE);
      in_range     = desc_ok(cand, idx);
      case (idx)
         MPR_I_ROTOR_HI, MPR_I_IND_HI, MPR_I_MAG_HI, MPR_I_INERT_HI, MPR_I_ACC1_HI,
         MPR_I_DEC1_HI, MPR_I_STEP_HI, MPR_I_ACC2_HI, MPR_I_DEC2_HI: begin
            ok = req_in.data <= MPR_DESC[idx].hi[31:16];
         end
         MPR_I_BASE: begin
            ok = (cand >= MPR_DESC[idx].lo) && (cand <= {16'h0000, word_q[MPR_I_MAX]});
         end
         MPR_I_MAX: begin
            ok = in_range && (cand >= {16'h0000, word_q[MPR_I_BASE]});
         end
         MPR_I_STEP_LO: begin
            ok = (cand == 32'h0000_0000) ||
                 ((cand >= STEP_START_MIN) && (cand <= step_ceiling));
         end
         MPR_I_CAP: begin
            ok = mpr_cap_legal(cand);
         end
         default: begin
            ok = in_range;
         end
      endcase
   end

   assign wr_commit = acc && req_in.write && hit && ok && !is_hi;

   // Committed words; a pair lands both halves in one edge
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         for (int i = 0; i < MPR_NUM_REGS; i++) begin
            word_q[i] <= MPR_DESC[i].rst;
         end
      end else if (wr_commit) begin
         word_q[idx] <= req_in.data;
         if (is_pair) begin
            word_q[{idx[4:1], 1'b0}] <= pend_hi[pair_sel];
         end
      end
   end

   // High halves wait here until the low half validates the whole value
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         for (int p = 0; p < MPR_NUM_PAIRS; p++) begin
            pend_hi[p] <= MPR_DESC[2*p].rst;
         end
      end else if (acc && req_in.write && is_hi && ok) begin
         pend_hi[pair_sel] <= req_in.data;
      end
   end

   // Answer one edge after the request; an accepted write echoes its data
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rsp_valid_out <= 1'b0;
         rsp_out       <= '0;
      end else if (ce_in) begin
         rsp_valid_out <= req_valid_in;
         if (req_valid_in) begin
            if (!hit) begin
               rsp_out <= {1'b1, MPR_EXC_ADDR, 16'h0000};
            end else if (req_in.write && !ok) begin
               rsp_out <= {1'b1, MPR_EXC_VALUE, 16'h0000};
            end else if (req_in.write) begin
               rsp_out <= {1'b0, MPR_EXC_NONE, req_in.data};
            end else begin
               rsp_out <= {1'b0, MPR_EXC_NONE, rd_word};
            end
         end
      end
   end

   assign param_words_out = word_q;

   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!rst_n_in);

   property p_rsp_latency;
      acc |=> rsp_valid_out;
   endproperty
   a_rsp_latency: assert property (p_rsp_latency)
      else $error("request not answered on the next edge");

   property p_unused_addr;
      acc && !hit |=> rsp_out.exc && (rsp_out.exc_code == MPR_EXC_ADDR) && $stable(word_q);
   endproperty
   a_unused_addr: assert property (p_unused_addr)
      else $error("unused address not refused");

   property p_reject_hold;
      acc && req_in.write && hit && !ok |=>
         rsp_out.exc && (rsp_out.exc_code == MPR_EXC_VALUE) && $stable(word_q);
   endproperty
   a_reject_hold: assert property (p_reject_hold)
      else $error("out-of-range write changed storage or was not refused");

   property p_hi_defer;
      acc && req_in.write && is_hi |=> $stable(word_q);
   endproperty
   a_hi_defer: assert property (p_hi_defer)
      else $error("high half took effect before the low half");

   property p_pair_commit;
      logic [31:0] v;
      logic [4:0]  i;
      (wr_commit && is_pair, v = cand, i = idx) |=>
         ({word_q[{i[4:1], 1'b0}], word_q[i]} == v) && !rsp_out.exc;
   endproperty
   a_pair_commit: assert property (p_pair_commit)
      else $error("pair did not commit both halves together");

   property p_base_le_max;
      word_q[MPR_I_BASE] <= word_q[MPR_I_MAX];
   endproperty
   a_base_le_max: assert property (p_base_le_max)
      else $error("base frequency above max frequency");

   property p_thermal_range;
      ({16'h0000, word_q[MPR_I_THERM]} >= MPR_DESC[MPR_I_THERM].lo) &&
      ({16'h0000, word_q[MPR_I_THERM]} <= MPR_DESC[MPR_I_THERM].hi);
   endproperty
   a_thermal_range: assert property (p_thermal_range)
      else $error("thermal level out of range");

   property p_stab_range;
      {16'h0000, word_q[MPR_I_STAB]} <= MPR_DESC[MPR_I_STAB].hi;
   endproperty
   a_stab_range: assert property (p_stab_range)
      else $error("stabilization gain out of range");

   property p_cap_legal;
      mpr_cap_legal({16'h0000, word_q[MPR_I_CAP]});
   endproperty
   a_cap_legal: assert property (p_cap_legal)
      else $error("capacity code unassigned");

   property p_read_data;
      acc && !req_in.write && hit |=> !rsp_out.exc && (rsp_out.data == $past(rd_word));
   endproperty
   a_read_data: assert property (p_read_data)
      else $error("read answer does not match stored word");

   property p_freeze;
      !ce_in |=> $stable(word_q) && $stable(rsp_valid_out) && $stable(pend_hi);
   endproperty
   a_freeze: assert property (p_freeze)
      else $error("state moved while clock enable low");

   property p_rotor_range;
      desc_ok(pair_word(word_q, MPR_I_ROTOR_HI), MPR_I_ROTOR_HI);
   endproperty
   a_rotor_range: assert property (p_rotor_range)
      else $error("tuned rotor resistance pair out of range");

   property p_ind_range;
      desc_ok(pair_word(word_q, MPR_I_IND_HI), MPR_I_IND_HI);
   endproperty
   a_ind_range: assert property (p_ind_range)
      else $error("tuned inductance pair out of range");

   property p_mag_range;
      desc_ok(pair_word(word_q, MPR_I_MAG_HI), MPR_I_MAG_HI);
   endproperty
   a_mag_range: assert property (p_mag_range)
      else $error("tuned magnetizing current pair out of range");

   property p_inertia_range;
      desc_ok(pair_word(word_q, MPR_I_INERT_HI), MPR_I_INERT_HI);
   endproperty
   a_inertia_range: assert property (p_inertia_range)
      else $error("tuned inertia pair out of range");

   property p_acc1_range;
      desc_ok(pair_word(word_q, MPR_I_ACC1_HI), MPR_I_ACC1_HI);
   endproperty
   a_acc1_range: assert property (p_acc1_range)
      else $error("first accel time pair out of range");

   property p_dec1_range;
      desc_ok(pair_word(word_q, MPR_I_DEC1_HI), MPR_I_DEC1_HI);
   endproperty
   a_dec1_range: assert property (p_dec1_range)
      else $error("first decel time pair out of range");

   property p_acc2_range;
      desc_ok(pair_word(word_q, MPR_I_ACC2_HI), MPR_I_ACC2_HI);
   endproperty
   a_acc2_range: assert property (p_acc2_range)
      else $error("second accel time pair out of range");

   property p_dec2_range;
      desc_ok(pair_word(word_q, MPR_I_DEC2_HI), MPR_I_DEC2_HI);
   endproperty
   a_dec2_range: assert property (p_dec2_range)
      else $error("second decel time pair out of range");

   // Lowering max frequency later may leave the step above the new ceiling
   property p_step_range;
      (pair_word(word_q, MPR_I_STEP_HI) == 32'h0000_0000) ||
      ((pair_word(word_q, MPR_I_STEP_HI) >= STEP_START_MIN) &&
       desc_ok(pair_word(word_q, MPR_I_STEP_HI), MPR_I_STEP_HI));
   endproperty
   a_step_range: assert property (p_step_range)
      else $error("step speed zero pair out of range");

   property p_pi_range;
      word_ok(word_q, MPR_I_PI_P) && word_ok(word_q, MPR_I_PI_I);
   endproperty
   a_pi_range: assert property (p_pi_range)
      else $error("PI gain out of range");

   property p_p_range;
      word_ok(word_q, MPR_I_P_P);
   endproperty
   a_p_range: assert property (p_p_range)
      else $error("P proportional gain out of range");

   property p_zero_boost_range;
      word_ok(word_q, MPR_I_ZERO) && word_ok(word_q, MPR_I_BOOST);
   endproperty
   a_zero_boost_range: assert property (p_zero_boost_range)
      else $error("zero hz limit or start boost out of range");

   property p_max_range;
      word_ok(word_q, MPR_I_MAX);
   endproperty
   a_max_range: assert property (p_max_range)
      else $error("max frequency out of range");

   property p_tboost_range;
      word_ok(word_q, MPR_I_TBV) && word_ok(word_q, MPR_I_TBF);
   endproperty
   a_tboost_range: assert property (p_tboost_range)
      else $error("torque boost word out of range");

   property p_mode_range;
      word_ok(word_q, MPR_I_CTRL) && word_ok(word_q, MPR_I_CURVE);
   endproperty
   a_mode_range: assert property (p_mode_range)
      else $error("control method or thermal curve out of range");

   property p_rsp_idle;
      ce_in && !req_valid_in |=> !rsp_valid_out;
   endproperty
   a_rsp_idle: assert property (p_rsp_idle)
      else $error("answer raised without a request");

   property p_exc_data;
      rsp_valid_out && rsp_out.exc |->
         (rsp_out.data == 16'h0000) && (rsp_out.exc_code != MPR_EXC_NONE);
   endproperty
   a_exc_data: assert property (p_exc_data)
      else $error("exception answer carries data or no code");

   property p_write_echo;
      acc && req_in.write && hit && ok |=>
         !rsp_out.exc && (rsp_out.data == $past(req_in.data));
   endproperty
   a_write_echo: assert property (p_write_echo)
      else $error("accepted write not answered normally");

   property p_pend_hold;
      logic [3:0]  s;
      logic [15:0] d;
      (acc && req_in.write && is_hi && ok, s = pair_sel, d = req_in.data) |=>
         (pend_hi[s] == d);
   endproperty
   a_pend_hold: assert property (p_pend_hold)
      else $error("accepted high half not held pending");

   property p_single_commit;
      logic [4:0]  i;
      logic [15:0] d;
      (wr_commit && !is_pair, i = idx, d = req_in.data) |=> (word_q[i] == d);
   endproperty
   a_single_commit: assert property (p_single_commit)
      else $error("accepted single write did not land");

   c_pair_commit: cover property (wr_commit && is_pair);
   c_range_reject: cover property (acc && req_in.write && hit && !ok);
   c_unused_addr: cover property (acc && !hit);
   c_step_zero: cover property (wr_commit && (idx == MPR_I_STEP_LO) && (cand == 32'h0000_0000));
   c_freeze: cover property (!ce_in && req_valid_in);

endmodule : mpr_bank

`default_nettype wire

/* File: mpr_master.sv */
`timescale 1ns/1ps
`default_nettype none
module mpr_master
   import mpr_pkg::*;
(
   // Clock
   input  wire logic         core_clk_in,
   // Request out, answer in
   output logic              req_valid_out,
   output mpr_req_type       req_out,
   input  wire logic         rsp_valid_in,
   input  wire mpr_rsp_type  rsp_in
);
   initial begin
      req_valid_out = 1'b0;
      req_out = '0;
   end

   // Caller gives the register number; the wire carries it minus one
   task automatic xfer(input logic wr, input logic [15:0] rn, input logic [15:0] d,
                       output logic ok, output mpr_rsp_type rsp);
      @(posedge core_clk_in);
      #1;
      req_out = '{wr, rn - MPR_ADDR_ADJUST, d};
      req_valid_out = 1'b1;
      @(posedge core_clk_in);
      #1;
      ok = rsp_valid_in;
      rsp = rsp_in;
      req_valid_out = 1'b0;
      // Idle lines scrambled so a stale request can never pass for a live one
      req_out = ~req_out;
   endtask : xfer
endmodule : mpr_master
`default_nettype wire

/* File: motor_param_register_bank_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module motor_param_register_bank_tb
   import mpr_pkg::*;
;
   logic                clk;
   logic                ce;
   logic                fz_ok;
   mpr_rsp_type         fz_rsp;
   logic                rst_n;
   logic                req_valid;
   mpr_req_type         req;
   logic                rsp_valid;
   mpr_rsp_type         rsp;
   mpr_word_array_type  words;
   int                  err_count;
   int                  checks;
   // Single registers: number, least, greatest
   localparam logic [15:0] LIM [9][3] = '{
      '{16'h253D, 16'h0000, 16'h2710}, '{16'h253E, 16'h0000, 16'h2710},
      '{16'h253F, 16'h0000, 16'h03E8}, '{16'h2547, 16'h0000, 16'h03E8},
      '{16'h2548, 16'h0000, 16'h0032}, '{16'h323C, 16'h0000, 16'h00C8},
      '{16'h323D, 16'h0000, 16'h01F4}, '{16'h330C, 16'h00C8, 16'h03E8},
      '{16'h3507, 16'h0000, 16'h00FF}};

   mpr_bank dut_u (.core_clk_in(clk), .rst_n_in(rst_n), .ce_in(ce),
      .req_valid_in(req_valid), .req_in(req), .rsp_valid_out(rsp_valid),
      .rsp_out(rsp), .param_words_out(words));
   mpr_master mst_u (.core_clk_in(clk), .req_valid_out(req_valid), .req_out(req),
      .rsp_valid_in(rsp_valid), .rsp_in(rsp));

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic wr(input logic [15:0] rn, input logic [15:0] d, input logic [7:0] code);
      logic        ok;
      mpr_rsp_type r;
      mst_u.xfer(1'b1, rn, d, ok, r);
      chk(ok, 32'h0000_0001);
      chk(r, {code != MPR_EXC_NONE, code, (code == MPR_EXC_NONE) ? d : 16'h0000});
   endtask : wr

   task automatic rd(input logic [15:0] rn, input logic [15:0] exp);
      logic        ok;
      mpr_rsp_type r;
      mst_u.xfer(1'b0, rn, 16'h0000, ok, r);
      chk(ok, 32'h0000_0001);
      chk(r, {1'b0, MPR_EXC_NONE, exp});
   endtask : rd

   task automatic summarize;
      $display("errors=%0d checks=%0d", err_count, checks);
      if (err_count == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : summarize

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // About 110 transfers of two cycles each; far below this bound
   initial begin
      #20000;
      err_count++;
      summarize();
   end

   initial begin
      err_count = 0;
      checks = 0;
      ce = 1'b1;
      rst_n = 1'b0;
      repeat (4) @(posedge clk);
      #1 rst_n = 1'b1;
      rd(16'h3203, 16'h003C);
      rd(16'h3104, 16'h0001);
      rd(16'h330C, 16'h03E8);
      wr(16'h252E, 16'h0001, MPR_EXC_ADDR);
      wr(16'h3103, 16'h0005, MPR_EXC_NONE);
      rd(16'h3103, 16'h0000);
      wr(16'h3104, 16'h7E40, MPR_EXC_NONE);
      chk(words[MPR_I_ACC1_HI], 16'h0005);
      chk(words[MPR_I_ACC1_LO], 16'h7E40);
      wr(16'h3105, 16'h0005, MPR_EXC_NONE);
      wr(16'h3106, 16'h7E41, MPR_EXC_VALUE);
      rd(16'h3105, 16'h0000);
      rd(16'h3106, 16'h0001);
      wr(16'h326D, 16'h0000, MPR_EXC_NONE);
      wr(16'h326E, 16'h0000, MPR_EXC_VALUE);
      wr(16'h326F, 16'h0005, MPR_EXC_NONE);
      wr(16'h3270, 16'h7E40, MPR_EXC_NONE);
      rd(16'h326F, 16'h0005);
      wr(16'h252A, 16'h0001, MPR_EXC_VALUE);
      wr(16'h252A, 16'h0000, MPR_EXC_NONE);
      wr(16'h252B, 16'hFFFF, MPR_EXC_NONE);
      rd(16'h252B, 16'hFFFF);
      wr(16'h252C, 16'h0098, MPR_EXC_NONE);
      wr(16'h252D, 16'h9299, MPR_EXC_VALUE);
      rd(16'h252C, 16'h0000);
      wr(16'h252D, 16'h9298, MPR_EXC_NONE);
      rd(16'h252C, 16'h0098);
      wr(16'h2527, 16'h0000, MPR_EXC_VALUE);
      wr(16'h2529, 16'h1234, MPR_EXC_NONE);
      rd(16'h2528, 16'h0000);
      rd(16'h2529, 16'h1234);
      for (int j = 0; j < 9; j++) begin
         wr(LIM[j][0], LIM[j][2] + 16'h0001, MPR_EXC_VALUE);
         wr(LIM[j][0], LIM[j][2], MPR_EXC_NONE);
         if (LIM[j][1] != 16'h0000) begin
            wr(LIM[j][0], LIM[j][1] - 16'h0001, MPR_EXC_VALUE);
         end
         rd(LIM[j][0], LIM[j][2]);
      end
      // Frozen bank ignores the request and keeps its last answer
      @(posedge clk);
      #1 ce = 1'b0;
      mst_u.xfer(1'b1, 16'h253D, 16'h0001, fz_ok, fz_rsp);
      ce = 1'b1;
      chk(fz_ok, 32'h0000_0000);
      chk(fz_rsp, {1'b0, MPR_EXC_NONE, 16'h00FF});
      chk(words[MPR_I_PI_P], 16'h2710);
      rd(16'h253D, 16'h2710);
      wr(16'h323E, 16'h0002, MPR_EXC_VALUE);
      wr(16'h323E, 16'h0001, MPR_EXC_NONE);
      rd(16'h323E, 16'h0001);
      wr(16'h330D, 16'h0003, MPR_EXC_VALUE);
      wr(16'h330D, 16'h0002, MPR_EXC_NONE);
      rd(16'h330D, 16'h0002);
      wr(16'h3204, 16'h0191, MPR_EXC_VALUE);
      wr(16'h3204, 16'h0190, MPR_EXC_NONE);
      wr(16'h3203, 16'h0190, MPR_EXC_NONE);
      wr(16'h3204, 16'h0064, MPR_EXC_VALUE);
      wr(16'h3203, 16'h001D, MPR_EXC_VALUE);
      wr(16'h3203, 16'h001E, MPR_EXC_NONE);
      wr(16'h3204, 16'h0064, MPR_EXC_NONE);
      wr(16'h3203, 16'h0065, MPR_EXC_VALUE);
      rd(16'h3203, 16'h001E);
      wr(16'h3216, 16'h0000, MPR_EXC_NONE);
      wr(16'h3217, 16'h0000, MPR_EXC_NONE);
      wr(16'h3217, 16'h0031, MPR_EXC_VALUE);
      wr(16'h3217, 16'h0032, MPR_EXC_NONE);
      wr(16'h3217, 16'h2711, MPR_EXC_VALUE);
      wr(16'h3217, 16'h2710, MPR_EXC_NONE);
      rd(16'h3217, 16'h2710);
      for (int i = 0; i < 26; i++) begin
         wr(16'h2503, i[15:0], (i <= 24 && !(i inside {1, 3, 5, 8, 10})) ?
            MPR_EXC_NONE : MPR_EXC_VALUE);
      end
      rd(16'h2503, 16'h0018);
      // Reset in mid-run brings back the reset words
      rst_n = 1'b0;
      @(posedge clk);
      #1 rst_n = 1'b1;
      rd(16'h3217, 16'h0000);
      rd(16'h3204, 16'h003C);
      chk(words[MPR_I_CAP], 16'h0000);
      summarize();
   end
endmodule : motor_param_register_bank_tb
`default_nettype wire
